// File: rtl/period_gate.sv
// Purpose: gating and arming of a reciprocal period counter
// Assumes: signal_i and ext_gate_i synchronous to clk_i; rising edge is a cycle
// Notes: registers over classic Wishbone, 32-bit words
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module period_gate
   import gate_pkg::*;
#(
   parameter int TICK_W = 32,
   parameter int CYC_W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // measured signal and trigger
   input wire logic signal_i,
   input wire logic ext_gate_i,
   // gate window and result
   output logic gate_window_o,
   output logic armed_o,
   output logic result_valid_o
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_GATE = 2'b11,
      ST_CLOSE = 2'b10
   } meas_state_e;

   typedef struct packed {
      meas_state_e st;
      logic [31:0] ctrl;
      logic [TICK_W-1:0] ticks;
      logic [CYC_W-1:0] cycles;
      logic [TICK_W-1:0] ticks_res;
      logic [CYC_W-1:0] cycles_res;
      logic valid;
      logic externally_armed_position_seen;
      logic ext_done;
      logic window;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } gate_state_s;
   gate_state_s s_q, s_d;

   logic sig_rise, ext_rise, ext_fall, nominal_done, tb_start;
   logic [2:0] decade;
   logic [3:0] scale;
   gate_mode_e mode;
   logic arm_source_select;
   logic high_band;
   logic wb_req;

   assign decade = s_q.ctrl[CTRL_DECADE_LSB +: 3];
   assign scale = s_q.ctrl[CTRL_SCALE_LSB +: 4];
   assign mode = gate_mode_e'(s_q.ctrl[CTRL_MODE_LSB +: 2]);
   assign arm_source_select = s_q.ctrl[CTRL_ARMSRC_BIT];
   assign high_band = s_q.ctrl[CTRL_BAND_BIT];
   assign wb_req = cyc_i & stb_i & ~s_q.ack & ~s_q.err;

   edge_detect sig_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(signal_i),
      .rise_o(sig_rise),
      .fall_o()
   );

   edge_detect ext_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(ext_gate_i),
      .rise_o(ext_rise),
      .fall_o(ext_fall)
   );

   // time base restarts as the gate opens
   assign tb_start = (s_q.st == ST_ARMED) & sig_rise;

   time_base tb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .decade_i(decade),
      .scale_i(scale),
      .start_i(tb_start),
      .elapsed_o(nominal_done)
   );

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] wr,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wr[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic stop_now;
   always_comb begin
      stop_now = 1'b0;
      unique case (mode)
         GATE_TIMEBASE: stop_now = sig_rise & nominal_done;
         GATE_MIN_CYCLE: begin
            // one cycle low band, 32 cycles high band
            if (high_band) begin
               stop_now = sig_rise &
                  (s_q.cycles == CYC_W'(HIGH_BAND_MIN_CYCLES - 1));
            end else begin
               stop_now = sig_rise;
            end
         end
         external_gate_duration_mode: stop_now = sig_rise & (s_q.ext_done | ext_fall);
         default: stop_now = sig_rise;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.err = 1'b0;

      // bus slave
      if (wb_req) begin
         unique case (adr_i)
            CTRL_OFS: begin
               s_d.ack = 1'b1;
               s_d.rdata = s_q.ctrl;
               if (we_i) begin
                  s_d.ctrl = merge_bytes(s_q.ctrl, dat_i, sel_i);
               end
            end
            STAT_OFS: begin
               s_d.ack = 1'b1;
               s_d.rdata = {28'h0, s_q.valid, s_q.window, s_q.st == ST_ARMED,
                            s_q.st != ST_IDLE};
               if (we_i && sel_i[0] && dat_i[3]) begin
                  s_d.valid = 1'b0;
               end
            end
            TICKS_OFS: begin
               s_d.ack = 1'b1;
               s_d.rdata = 32'(s_q.ticks_res);
            end
            CYCLES_OFS: begin
               s_d.ack = 1'b1;
               s_d.rdata = 32'(s_q.cycles_res);
            end
            default: begin
               s_d.err = 1'b1;
               s_d.rdata = 32'h0;
            end
         endcase
      end

      // trigger edge latched; shape afterwards irrelevant
      if (ext_rise) begin
         s_d.externally_armed_position_seen = 1'b1;
      end

      unique case (s_q.st)
         ST_IDLE: begin
            s_d.window = 1'b0;
            if (arm_source_select) begin
               s_d.st = ST_ARMED;
               s_d.externally_armed_position_seen = 1'b0;
            end else if (s_q.externally_armed_position_seen | ext_rise) begin
               // armed one cycle after the edge, well inside 100 ns
               s_d.st = ST_ARMED;
               s_d.externally_armed_position_seen = 1'b0;
            end
         end
         ST_ARMED: begin
            if (sig_rise) begin
               s_d.st = ST_GATE;
               s_d.window = 1'b1;
               s_d.ticks = '0;
               s_d.cycles = '0;
               s_d.ext_done = 1'b0;
            end
         end
         ST_GATE: begin
            s_d.ticks = s_q.ticks + TICK_W'(1);
            if (ext_fall) begin
               s_d.ext_done = 1'b1;
            end
            if (sig_rise) begin
               s_d.cycles = s_q.cycles + CYC_W'(1);
            end
            if (stop_now) begin
               s_d.st = ST_CLOSE;
               s_d.window = 1'b0;
            end
         end
         ST_CLOSE: begin
            // results for arithmetic conversion by software
            s_d.ticks_res = s_q.ticks;
            s_d.cycles_res = s_q.cycles;
            s_d.valid = 1'b1;
            // a trigger edge in this very cycle still arms the next run
            s_d.externally_armed_position_seen = ext_rise;
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.ctrl <= CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.rdata;
   assign ack_o = s_q.ack;
   assign err_o = s_q.err;
   assign gate_window_o = s_q.window;
   assign armed_o = (s_q.st == ST_ARMED);
   assign result_valid_o = s_q.valid;
endmodule

// File: rtl/gate_pkg.sv
// Purpose: constants for the reciprocal period counter gate
// Assumes: 25 MHz system clock
// Notes: Wishbone register map for settings and results
package gate_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int ARM_LATENCY_NS = 100;
   localparam int ARM_LATENCY_CYC_RAW = (ARM_LATENCY_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int ARM_LATENCY_CYC = (ARM_LATENCY_CYC_RAW < 1) ? 1 : ARM_LATENCY_CYC_RAW;
   localparam int TIME_BASE_1US_CYC = CLK_HZ / 1000000;
   localparam int HIGH_BAND_MIN_CYCLES = 32;
   localparam int SCALE_MAX = 9;
   localparam int DECADE_MAX = 7;
   // register offsets (byte addresses)
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] TICKS_OFS = 4'h8;
   localparam logic [3:0] CYCLES_OFS = 4'hC;
   // control field positions
   localparam int CTRL_DECADE_LSB = 0;
   localparam int CTRL_SCALE_LSB = 4;
   localparam int CTRL_MODE_LSB = 8;
   localparam int CTRL_ARMSRC_BIT = 10;
   localparam int CTRL_BAND_BIT = 11;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   typedef enum logic [1:0] {
      GATE_TIMEBASE = 2'h0,
      GATE_MIN_CYCLE = 2'h1,
      external_gate_duration_mode = 2'h2
   } gate_mode_e;
endpackage

// File: rtl/edge_detect.sv
// Purpose: rising and falling edge pulses of a synchronous level
// Assumes: input already synchronous to clk_i
// Notes: one-cycle pulses
`timescale 1ns/10ps
module edge_detect (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // level in, edges out
   input wire logic level_i,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic prev;
   } edge_state_s;
   edge_state_s s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.prev = level_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign rise_o = level_i & ~s_q.prev;
   assign fall_o = ~level_i & s_q.prev;
endmodule

// File: rtl/time_base.sv
// Purpose: decade time base times scale factor, flags nominal time elapsed
// Assumes: start pulse restarts the count
// Notes: decade 0 is 1 us, decade 7 is 10 s
`timescale 1ns/10ps
module time_base
   import gate_pkg::*;
#(
   parameter int US_CYC = gate_pkg::TIME_BASE_1US_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // settings
   input wire logic [2:0] decade_i,
   input wire logic [3:0] scale_i,
   // control
   input wire logic start_i,
   output logic elapsed_o
);
   typedef struct packed {
      logic [7:0] pre;
      logic [27:0] units;
      logic [3:0] mult;
      logic done;
   } tb_state_s;
   tb_state_s s_q, s_d;

   function automatic logic [27:0] decade_units(input logic [2:0] d);
      logic [27:0] v;
      v = 28'h1;
      for (int i = 0; i < DECADE_MAX; i++) begin
         if (3'(i) < d) begin
            v = 28'(v * 28'hA);
         end
      end
      return v;
   endfunction

   logic [3:0] scale_eff;
   assign scale_eff = (scale_i == 4'h0) ? 4'h1 :
                      (scale_i > 4'(SCALE_MAX)) ? 4'(SCALE_MAX) : scale_i;

   always_comb begin
      s_d = s_q;
      if (start_i) begin
         s_d.pre = '0;
         s_d.units = '0;
         s_d.mult = '0;
         s_d.done = 1'b0;
      end else if (!s_q.done) begin
         if (s_q.pre == 8'(US_CYC - 1)) begin
            s_d.pre = '0;
            if (s_q.units == decade_units(decade_i) - 28'h1) begin
               s_d.units = '0;
               if (s_q.mult == scale_eff - 4'h1) begin
                  s_d.done = 1'b1;
               end else begin
                  s_d.mult = s_q.mult + 4'h1;
               end
            end else begin
               s_d.units = s_q.units + 28'h1;
            end
         end else begin
            s_d.pre = s_q.pre + 8'h1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign elapsed_o = s_q.done;
endmodule

// File: dv/period_gate_props.sv
// Purpose: port timing checks for period_gate
// Assumes: ack or err one cycle after take
// Notes: bound from tb
`timescale 1ns/10ps
module period_gate_props (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic err_o,
   // measurement
   input wire logic signal_i,
   input wire logic gate_window_o,
   input wire logic armed_o,
   input wire logic result_valid_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_rise;
      signal_i && !$past(signal_i);
   endsequence
   property p_reply;
      s_take |=> (ack_o || err_o);
   endproperty
   property p_pulse;
      (ack_o || err_o) |=> !(ack_o || err_o);
   endproperty
   property p_open;
      armed_o ##0 s_rise |=> gate_window_o;
   endproperty
   property p_open_armed;
      $rose(gate_window_o) |-> $past(armed_o);
   endproperty
   property p_close;
      $fell(gate_window_o) |-> $past(signal_i) && !$past(signal_i, 2);
   endproperty
   property p_hold;
      gate_window_o && !(signal_i && !$past(signal_i)) |=> gate_window_o;
   endproperty
   property p_valid;
      $fell(gate_window_o) |=> result_valid_o;
   endproperty
   property p_excl;
      !(armed_o && gate_window_o);
   endproperty
   property p_reset;
      disable iff (1'b0) rst_i |=> !gate_window_o && !armed_o && !ack_o && !result_valid_o;
   endproperty
   a_reply: assert property (p_reply) else $error("no bus reply");
   a_pulse: assert property (p_pulse) else $error("reply too long");
   a_open: assert property (p_open) else $error("gate not opened");
   a_open_armed: assert property (p_open_armed) else $error("open unarmed");
   a_close: assert property (p_close) else $error("close off cycle");
   a_hold: assert property (p_hold) else $error("gate dropped");
   a_valid: assert property (p_valid) else $error("no result");
   a_excl: assert property (p_excl) else $error("armed in gate");
   a_reset: assert property (p_reset) else $error("reset state");
endmodule

// File: dv/signal_source.sv
// Purpose: measured signal and trigger pulse source
// Assumes: outputs change on rising edge
// Notes: signal rests low while stopped
`timescale 1ns/10ps
module signal_source (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [3:0] half_i,
   input wire logic fire_i,
   input wire logic [7:0] width_i,
   // outputs
   output logic signal_o,
   output logic ext_gate_o
);
   logic [3:0] ph_q;
   logic [7:0] left_q;
   // burst stays on through the gate
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         ph_q <= 4'h0;
         signal_o <= 1'b0;
      end else if (ph_q + 4'h1 >= half_i) begin
         ph_q <= 4'h0;
         signal_o <= !signal_o;
      end else begin
         ph_q <= ph_q + 4'h1;
      end
   end
   // pulse of width_i cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_q <= 8'h00;
      end else if (fire_i) begin
         left_q <= width_i;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign ext_gate_o = (left_q != 8'h00);
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for period_gate
// Assumes: 25 MHz clock, sync reset
// Notes: bus replies checked from a queue
`timescale 1ns/10ps
module tb;
   import gate_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
   exp_s exp_q[$];
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hF, half = 4'h5, wsel = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, rd, t;
   logic ack_o, err_o, signal_i, ext_gate_i, gate_window_o, armed_o, result_valid_o;
   logic run = 1'b0, fire = 1'b0;
   logic [7:0] width = 8'h01;
   int n_errors = 0, samples_checked = 0, cycles = 0, run_len = 0, last_width = 0;
   int seed = 32'hcae2cceb, h, n, c;
   int tb_dec[4] = '{0, 0, 0, 1}, tb_sc[4] = '{1, 3, 9, 1}, tb_h[4] = '{5, 5, 5, 8};
   period_gate i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
      .signal_i(signal_i), .ext_gate_i(ext_gate_i), .gate_window_o(gate_window_o),
      .armed_o(armed_o), .result_valid_o(result_valid_o));
   signal_source i_src (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .half_i(half),
      .fire_i(fire), .width_i(width), .signal_o(signal_i), .ext_gate_o(ext_gate_i));
   initial begin
      forever #20 clk_i = !clk_i;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
         input logic [31:0] ed, input logic [31:0] em, input logic ee);
      exp_q.push_back('{ed, em, ee});
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= wsel;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wait_valid();
      while (result_valid_o !== 1'b1) @(posedge clk_i);
   endtask
   task automatic measure(input logic [31:0] ctrl, input logic [31:0] et,
         input logic [31:0] ec, input logic [31:0] m, input logic [31:0] p);
      wb(1'b1, CTRL_OFS, ctrl, 32'h0, 32'h0, 1'b0);
      wb(1'b1, STAT_OFS, 32'h8, 32'h0, 32'h0, 1'b0);
      if (ctrl[CTRL_ARMSRC_BIT]) begin
         wait_valid();
         wb(1'b1, STAT_OFS, 32'h8, 32'h0, 32'h0, 1'b0);
      end else begin
         repeat (20) @(posedge clk_i);
         check(armed_o === 1'b0, "armed early");
         fire <= 1'b1;
         @(posedge clk_i);
         fire <= 1'b0;
         repeat (ARM_LATENCY_CYC + 1) @(posedge clk_i);
         check(armed_o === 1'b1 || gate_window_o === 1'b1, "arm late");
      end
      wait_valid();
      wb(1'b0, TICKS_OFS, 32'h0, et, m, 1'b0);
      t = rd;
      check(t === 32'(last_width), "window width");
      wb(1'b0, CYCLES_OFS, 32'h0, ec, m, 1'b0);
      check(t === rd * p, "ticks per cycle");
      if (ctrl[CTRL_ARMSRC_BIT]) begin
         check(armed_o === 1'b1 || gate_window_o === 1'b1, "no rearm");
      end else begin
         repeat (20) @(posedge clk_i);
         check(armed_o === 1'b0 && gate_window_o === 1'b0, "rearmed");
      end
      $display("test ctrl %h done", ctrl);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
      if (gate_window_o === 1'b1) begin
         run_len++;
      end else if (run_len != 0) begin
         last_width = run_len;
         run_len = 0;
      end
      if (!rst_i && (ack_o === 1'b1 || err_o === 1'b1)) begin
         check(exp_q.size() > 0 && err_o === exp_q[0].e
            && (dat_o & exp_q[0].m) === (exp_q[0].d & exp_q[0].m), "bus reply");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CTRL_OFS, 32'h0, CTRL_RESET, 32'hFFF, 1'b0);
      wb(1'b0, STAT_OFS, 32'h0, 32'h0, 32'hF, 1'b0);
      wb(1'b1, 4'h2, 32'h1234, 32'h0, 32'h0, 1'b1);
      wb(1'b0, CTRL_OFS, 32'h0, CTRL_RESET, 32'hFFF, 1'b0);
      wsel = 4'h2;
      wb(1'b1, CTRL_OFS, 32'h0000_03AA, 32'h0, 32'h0, 1'b0);
      wsel = 4'hF;
      wb(1'b0, CTRL_OFS, 32'h0, 32'h0000_0310, 32'hFFF, 1'b0);
      $display("test reset done");
      h = $unsigned($random(seed)) % 8 + 2;
      half <= h[3:0];
      width <= 8'($unsigned($random(seed)) % 8 + 1);
      run <= 1'b1;
      measure(32'h110, 32'(2 * h), 32'h1, '1, 32'(2 * h));
      half <= 4'h5;
      width <= 8'd60;
      measure(32'h210, 32'h0, 32'h0, 32'h0, 32'd10);
      check(rd >= 32'd5 && rd <= 32'd7, "external length");
      measure(32'hD10, 32'd320, 32'd32, '1, 32'd10);
      foreach (tb_dec[i]) begin
         half <= 4'(tb_h[i]);
         n = TIME_BASE_1US_CYC * (10 ** tb_dec[i]) * tb_sc[i];
         c = n / (2 * tb_h[i]) + 1;
         measure(32'h400 | 32'(tb_sc[i] << CTRL_SCALE_LSB) | 32'(tb_dec[i]),
            32'(c * 2 * tb_h[i]), 32'(c), '1, 32'(2 * tb_h[i]));
      end
      tally_and_finish();
   end
endmodule
bind period_gate period_gate_props i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .signal_i(signal_i),
   .gate_window_o(gate_window_o), .armed_o(armed_o), .result_valid_o(result_valid_o));
